// ==== verilog/psram_host.sv ====
// Host end of the burst link with its register port and read-data FIFO.
// Assumes software issues one-cycle strobes; memory answers on the same clock.
`timescale 1ns/10ps
module sync_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] buf_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire logic push = in_valid && in_ready;
  wire logic pop = out_valid && out_ready;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = buf_q[rd_q];
  assign level = cnt_q;
  always_ff @(posedge core_clk) begin
    if (push) begin
      buf_q[wr_q] <= in_data;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // sync_fifo
// Functional notes
// - first data after latency code plus one clocks
// - write wait asserted for latency count cycles
// - wait stays deasserted after defined read burst
// - bus data undefined past defined read burst
// - read end-of-row: select high within limit
// - write end-of-row: select high within limit
// - row crossing asserts wait for latency count
// - select high before edge after last write
// - refresh opportunity: clocked select high or 15ns
// - select low never beyond 4 microseconds
// - select high between different operation kinds
// - held select: async op on strobe fall
// - select high gap at least 5ns
module psram_host (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  psram_if.host link
);
  import psram_pkg::*;
  // ************************************************************
  // State
  // ************************************************************
  host_state_e state_q;
  logic [$clog2(LINK_DIV)-1:0] div_q;
  logic edge_q;
  logic ce_n_q;
  logic adv_n_q;
  logic we_n_q;
  logic [DQ_W-1:0] dq_q;
  logic oe_q;
  logic [15:0] cfg_q;
  logic [15:0] addr_reg_q;
  logic [15:0] len_reg_q;
  logic [15:0] wdata_reg_q;
  logic [15:0] cur_addr_q;
  logic [15:0] left_q;
  logic [15:0] wcur_q;
  logic pending_q;
  logic write_op_q;
  logic row_stop_q;
  logic row_hit_q;
  logic seen_data_q;
  logic [7:0] gap_q;
  logic [9:0] sel_q;
  logic [31:0] rdata_q;
  logic [FIFO_AW:0] level;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [DQ_W-1:0] fifo_out_data;
  // ************************************************************
  // Decode
  // ************************************************************
  wire logic wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
  wire logic busy = pending_q || (state_q != HOST_IDLE);
  wire logic go = wr_ctrl && reg_wdata[CTRL_GO_BIT] && !busy;
  wire logic pop = reg_rd && (reg_addr == REG_RDATA);
  // Read bursts restart only with room; stopping early is the back-pressure
  wire logic room = fifo_in_ready && (level < FIFO_DEPTH[FIFO_AW:0] - 2'd2);
  // Gap covers both refresh windows and the inter-operation minimum
  wire logic gap_ok = (gap_q >= HIGH_MIN_CYC[7:0]);
  wire logic launch = edge_q && (state_q == HOST_IDLE) && pending_q && gap_ok &&
                      (write_op_q || room);
  wire logic word = edge_q && (state_q == HOST_XFER) && link.wait_n;
  wire logic last = word && (left_q == 16'h0001);
  // Wait falling mid-burst marks end of row
  wire logic row_stop = edge_q && (state_q == HOST_XFER) && row_stop_q &&
                        seen_data_q && !link.wait_n;
  wire logic too_long = edge_q && (sel_q >= SELECT_LIMIT_CYC[9:0]);
  wire logic full_stop = word && !write_op_q && !room;
  wire logic finish = (state_q == HOST_XFER) &&
                      (last || row_stop || too_long || full_stop);
  wire logic push = word && !write_op_q && fifo_in_ready;
  sync_fifo #(
    .WIDTH(DQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rfifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(link.dq),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data),
    .level(level)
  );
  // ************************************************************
  // Link clock divider and select timers
  // ************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_q <= '0;
      edge_q <= 1'b0;
      gap_q <= 8'h00;
      sel_q <= 10'h000;
    end else begin
      div_q <= div_q + 1'b1;
      edge_q <= (div_q == '0);
      gap_q <= ce_n_q ? ((gap_q == 8'hff) ? gap_q : gap_q + 8'h01) : 8'h00;
      sel_q <= ce_n_q ? 10'h000 : sel_q + 10'h001;
    end
  end
  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= CFG_RESET;
      addr_reg_q <= 16'h0000;
      len_reg_q <= 16'h0000;
      wdata_reg_q <= 16'h0000;
      rdata_q <= 32'h0000_0000;
    end else begin
      if (reg_wr && (reg_addr == REG_CFG)) begin
        cfg_q <= reg_wdata[15:0];
      end
      if (reg_wr && (reg_addr == REG_ADDR)) begin
        addr_reg_q <= reg_wdata[15:0];
      end
      if (reg_wr && (reg_addr == REG_LEN)) begin
        len_reg_q <= reg_wdata[15:0];
      end
      if (reg_wr && (reg_addr == REG_WDATA)) begin
        wdata_reg_q <= reg_wdata[15:0];
      end
      rdata_q <= 32'h0000_0000;
      if (reg_rd) begin
        unique case (reg_addr)
          REG_ADDR: rdata_q <= {16'h0000, addr_reg_q};
          REG_LEN: rdata_q <= {16'h0000, len_reg_q};
          REG_WDATA: rdata_q <= {16'h0000, wdata_reg_q};
          REG_CFG: rdata_q <= {16'h0000, cfg_q};
          REG_STATUS: begin
            rdata_q[STAT_BUSY_BIT] <= busy;
            rdata_q[STAT_ROWHIT_BIT] <= row_hit_q;
            rdata_q[STAT_LEVEL_LO +: FIFO_AW+1] <= level;
          end
          REG_RDATA: rdata_q <= {16'h0000, fifo_out_valid ? fifo_out_data : 16'h0000};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end
  // ************************************************************
  // Burst sequencer
  // ************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= HOST_IDLE;
      ce_n_q <= 1'b1;
      adv_n_q <= 1'b1;
      we_n_q <= 1'b1;
      dq_q <= 16'h0000;
      oe_q <= 1'b0;
      cur_addr_q <= 16'h0000;
      left_q <= 16'h0000;
      wcur_q <= 16'h0000;
      pending_q <= 1'b0;
      write_op_q <= 1'b0;
      row_stop_q <= 1'b0;
      row_hit_q <= 1'b0;
      seen_data_q <= 1'b0;
    end else if (go) begin
      pending_q <= (reg_wdata[31:16] != 16'h0000) ? 1'b0 : (len_reg_q != 16'h0000);
      write_op_q <= reg_wdata[CTRL_WRITE_BIT];
      row_stop_q <= reg_wdata[CTRL_ROWSTOP_BIT];
      row_hit_q <= 1'b0;
      cur_addr_q <= addr_reg_q;
      left_q <= len_reg_q;
      wcur_q <= wdata_reg_q;
    end else if (launch) begin
      // Every access opens with select freshly low after a gap
      ce_n_q <= 1'b0;
      adv_n_q <= 1'b0;
      we_n_q <= !write_op_q;
      dq_q <= cur_addr_q;
      oe_q <= 1'b1;
      seen_data_q <= 1'b0;
      state_q <= HOST_CMD;
    end else if (edge_q && (state_q == HOST_CMD)) begin
      adv_n_q <= 1'b1;
      dq_q <= wcur_q;
      oe_q <= write_op_q;
      state_q <= HOST_XFER;
    end else if (state_q == HOST_XFER) begin
      if (word) begin
        seen_data_q <= 1'b1;
        cur_addr_q <= cur_addr_q + 16'h0001;
        left_q <= left_q - 16'h0001;
        wcur_q <= wcur_q + 16'h0001;
        dq_q <= wcur_q + 16'h0001;
      end
      if (finish) begin
        // Select rises before the next edge; no stray words are taken
        ce_n_q <= 1'b1;
        oe_q <= 1'b0;
        state_q <= HOST_IDLE;
        if (last || row_stop) begin
          pending_q <= 1'b0;
        end
        if (row_stop) begin
          row_hit_q <= 1'b1;
        end
      end
    end
  end
  assign link.mem_clk_edge = edge_q;
  assign link.ce_n = ce_n_q;
  assign link.addr_valid_n = adv_n_q;
  assign link.we_n = we_n_q;
  assign link.host_dq = dq_q;
  assign link.host_oe = oe_q;
  assign link.bus_config_reg = cfg_q;
  assign reg_rdata = rdata_q;
endmodule // psram_host

// ==== pkg/psram_pkg.sv ====
// Shared constants, types and helpers for the burst memory link.
// Assumes a single 100 MHz core clock on both ends of the link.
package psram_pkg;

  // ************************************************************
  // Widths and sizes
  // ************************************************************
  localparam int DQ_W = 16;
  localparam int MEM_AW = 8;
  localparam int ROW_W = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam int LINK_DIV = 2;

  // ************************************************************
  // Configuration register fields and reset value
  // ************************************************************
  localparam int CFG_OPMODE_BIT = 15;
  localparam int CFG_FIXED_BIT = 14;
  localparam int CFG_LC_HI = 13;
  localparam int CFG_LC_LO = 11;
  localparam int CFG_WAIT_DLY_BIT = 8;
  localparam int CFG_BL_HI = 2;
  localparam int CFG_BL_LO = 0;
  localparam logic [15:0] CFG_RESET = 16'h1807;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SELECT_HIGH_GAP_NS = 5;
  localparam int REFRESH_HIGH_NS = 15;
  localparam int MAX_SELECT_PULSE_NS = 4000;
  localparam int SELECT_HIGH_GAP_CYC = (SELECT_HIGH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_HIGH_CYC = (REFRESH_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIGH_MIN_CYC = (REFRESH_HIGH_CYC > SELECT_HIGH_GAP_CYC) ?
                                REFRESH_HIGH_CYC : SELECT_HIGH_GAP_CYC;
  localparam int MAX_SELECT_PULSE_CYC = MAX_SELECT_PULSE_NS / CLK_PERIOD_NS;
  localparam int SELECT_LIMIT_CYC = MAX_SELECT_PULSE_CYC - 2 * LINK_DIV;

  // ************************************************************
  // Host register map (word index) and control bits
  // ************************************************************
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_ADDR = 3'h1;
  localparam logic [2:0] REG_LEN = 3'h2;
  localparam logic [2:0] REG_WDATA = 3'h3;
  localparam logic [2:0] REG_CFG = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;
  localparam logic [2:0] REG_RDATA = 3'h6;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int CTRL_ROWSTOP_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ROWHIT_BIT = 1;
  localparam int STAT_LEVEL_LO = 8;

  // ************************************************************
  // State types
  // ************************************************************
  typedef enum logic [3:0] {
    DEV_IDLE = 4'b0001,
    DEV_LAT  = 4'b0010,
    DEV_DATA = 4'b0100,
    DEV_DONE = 4'b1000
  } dev_state_e;

  typedef enum logic [2:0] {
    HOST_IDLE = 3'b001,
    HOST_CMD  = 3'b010,
    HOST_XFER = 3'b100
  } host_state_e;

  // Burst length code to words; zero means continuous
  function automatic logic [5:0] burst_words(input logic [2:0] code);
    logic [5:0] w;
    w = 6'h00;
    unique case (code)
      3'h0: w = 6'h04;
      3'h1: w = 6'h08;
      3'h2: w = 6'h10;
      3'h3: w = 6'h20;
      default: w = 6'h00;
    endcase
    return w;
  endfunction

endpackage

// ==== pkg/psram_if.sv ====
// Multiplexed address/data link between host controller and memory.
// Assumes both ends run on the same core clock; link clock is an edge pulse.
`timescale 1ns/10ps
interface psram_if;
  import psram_pkg::*;
  logic mem_clk_edge;
  logic ce_n;
  logic addr_valid_n;
  logic we_n;
  logic [15:0] bus_config_reg;
  logic [DQ_W-1:0] host_dq;
  logic host_oe;
  logic [DQ_W-1:0] dev_dq;
  logic dev_oe;
  logic wait_n;
  logic [DQ_W-1:0] dq;

  // Wire level from the two enables
  assign dq = host_oe ? host_dq : (dev_oe ? dev_dq : '0);

  modport host (
    output mem_clk_edge, ce_n, addr_valid_n, we_n, bus_config_reg, host_dq, host_oe,
    input wait_n, dq
  );
  modport dev (
    input mem_clk_edge, ce_n, addr_valid_n, we_n, bus_config_reg, dq,
    output dev_dq, dev_oe, wait_n
  );
endinterface

// ==== verilog/psram_dev.sv ====
// Memory end of the burst link: latency, wait, burst and row crossing.
// Assumes the host drives the link from logic on the same core clock.
`timescale 1ns/10ps
module psram_dev (
  input wire logic core_clk,
  input wire logic rst,
  psram_if.dev link,
  output logic busy
);
  import psram_pkg::*;

  // ************************************************************
  // Storage and state
  // ************************************************************
  logic [DQ_W-1:0] mem_q [2**MEM_AW];
  dev_state_e state_q;
  logic [MEM_AW-1:0] addr_q;
  logic [2:0] lat_q;
  logic [5:0] cnt_q;
  logic write_q;
  logic wait_n_q;
  logic [DQ_W-1:0] dq_q;
  logic oe_q;
  logic busy_q;
  logic adv_n_q;

  // ************************************************************
  // Decode
  // ************************************************************
  wire logic [2:0] lc = link.bus_config_reg[CFG_LC_HI:CFG_LC_LO];
  wire logic fixed_lat = link.bus_config_reg[CFG_FIXED_BIT];
  wire logic [5:0] blen = burst_words(link.bus_config_reg[CFG_BL_HI:CFG_BL_LO]);
  wire logic edge_now = link.mem_clk_edge;
  wire logic start_sync = edge_now && !link.addr_valid_n && (state_q == DEV_IDLE);
  // Held select after a fixed-latency read: new access on the strobe's fall
  wire logic start_async = (state_q == DEV_DONE) && fixed_lat && !write_q &&
                           adv_n_q && !link.addr_valid_n;
  wire logic start = !link.ce_n && (start_sync || start_async);
  // Code n gives n+1 clocks to first data and wait for n edges; code 0 acts as code 1
  wire logic [2:0] lat_load = (lc == 3'h0) ? 3'h0 : lc - 3'h1;
  wire logic [MEM_AW-1:0] next_addr = addr_q + 8'h01;
  wire logic row_end = &addr_q[ROW_W-1:0];
  wire logic [5:0] cnt_next = cnt_q + 6'h01;
  wire logic last_word = (blen != 6'h00) && (cnt_next == blen);
  wire logic xfer = edge_now && !link.ce_n && !start && (state_q == DEV_DATA);

  always_ff @(posedge core_clk) begin
    if (xfer && write_q) begin
      mem_q[addr_q] <= link.dq;
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= DEV_IDLE;
      addr_q <= 8'h00;
      lat_q <= 3'h0;
      cnt_q <= 6'h00;
      write_q <= 1'b0;
      wait_n_q <= 1'b1;
      dq_q <= 16'h0000;
      oe_q <= 1'b0;
      busy_q <= 1'b0;
      adv_n_q <= 1'b1;
    end else begin
      adv_n_q <= link.addr_valid_n;
      if (link.ce_n) begin
        state_q <= DEV_IDLE;
        wait_n_q <= 1'b1;
        oe_q <= 1'b0;
        busy_q <= 1'b0;
      end else if (start) begin
        addr_q <= link.dq[MEM_AW-1:0];
        write_q <= !link.we_n;
        cnt_q <= 6'h00;
        lat_q <= lat_load;
        state_q <= DEV_LAT;
        wait_n_q <= 1'b0;
        oe_q <= 1'b0;
        busy_q <= 1'b1;
      end else if (edge_now) begin
        unique case (state_q)
          DEV_LAT: begin
            if (lat_q != 3'h0) begin
              lat_q <= lat_q - 3'h1;
            end else begin
              state_q <= DEV_DATA;
              wait_n_q <= 1'b1;
              oe_q <= !write_q;
              dq_q <= mem_q[addr_q];
            end
          end
          DEV_DATA: begin
            addr_q <= next_addr;
            cnt_q <= cnt_next;
            if (last_word) begin
              // Wait stays high while select lingers; bus no longer driven
              state_q <= DEV_DONE;
              wait_n_q <= 1'b1;
              oe_q <= 1'b0;
              busy_q <= 1'b0;
            end else if (row_end) begin
              state_q <= DEV_LAT;
              lat_q <= lat_load;
              wait_n_q <= 1'b0;
              oe_q <= 1'b0;
            end else begin
              dq_q <= mem_q[next_addr];
            end
          end
          DEV_IDLE, DEV_DONE: begin
          end
        endcase
      end
    end
  end

  assign link.wait_n = wait_n_q;
  assign link.dev_dq = dq_q;
  assign link.dev_oe = oe_q;
  assign busy = busy_q;
endmodule // psram_dev

// ==== tb/psram_monitor.sv ====
// Checker for the burst memory link, watching the shared interface.
// Assumes both ends share core_clk and the link edge pulse.
`timescale 1ns/10ps
module psram_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic mem_clk_edge,
  input wire logic ce_n,
  input wire logic addr_valid_n,
  input wire logic we_n,
  input wire logic [15:0] bus_config_reg,
  input wire logic dev_oe,
  input wire logic wait_n
);
  import psram_pkg::*;
  // ********
  // Helpers
  // ********
  logic [9:0] low_q;
  logic [9:0] low_d;
  logic start;
  logic [2:0] lc;
  assign start = mem_clk_edge && !ce_n && !addr_valid_n;
  assign lc = bus_config_reg[CFG_LC_HI:CFG_LC_LO];
  // Counter, since a repetition cannot span hundreds of cycles
  assign low_d = ce_n ? 10'h000 : low_q + 10'h001;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      low_q <= 10'h000;
    end else begin
      low_q <= low_d;
    end
  end
  default clocking mon_cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ********
  // Properties
  // ********
  a_select_max_width: assert property (int'(low_q) <= MAX_SELECT_PULSE_CYC)
    else $error("select held low too long");
  a_select_high_gap: assert property ($rose(ce_n) |=> ce_n)
    else $error("select high gap too short");
  a_refresh_edge_seen: assert property ($rose(ce_n) |-> ##[0:2] (ce_n && mem_clk_edge))
    else $error("select high not clocked");
  a_wait_on_start: assert property (start |=> !wait_n)
    else $error("wait not raised after address");
  a_latency_code_two: assert property (start && lc == 3'h2 |-> ##1 (!wait_n)[*4] ##[1:2] wait_n)
    else $error("latency for code 2 wrong");
  a_latency_code_three: assert property (start && lc == 3'h3 |-> ##1 (!wait_n)[*6] ##[1:2] wait_n)
    else $error("latency for code 3 wrong");
  a_latency_code_four: assert property (start && lc == 3'h4 |-> ##1 (!wait_n)[*8] ##[1:2] wait_n)
    else $error("latency for code 4 wrong");
  a_idle_wait_high: assert property ($past(ce_n) && ce_n |-> wait_n)
    else $error("wait low while deselected");
  a_read_drive_only: assert property ($rose(dev_oe) |-> we_n && !ce_n)
    else $error("memory drives outside a read");
  a_strobe_one_period: assert property ($fell(addr_valid_n) |-> !ce_n ##1 !addr_valid_n ##1 addr_valid_n)
    else $error("address strobe width wrong");
endmodule // psram_monitor

// ==== tb/testbench.sv ====
// Bench joining host and memory ends through the link interface.
// Assumes the package, interface and both design ends are compiled first.
`timescale 1ns/10ps
module testbench;
  import psram_pkg::*;
  // ********
  // Signals and instances
  // ********
  logic core_clk;
  logic rst;
  logic [2:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic dev_busy;
  logic [31:0] rv;
  logic [15:0] cfg_tab [3] = '{16'h1000, 16'h1800, 16'h6000};
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  int edge_cnt = 0;
  int lat_seen = 0;
  psram_if link_if();
  psram_host psram_host_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link(link_if.host));
  psram_dev psram_dev_i (.core_clk(core_clk), .rst(rst), .link(link_if.dev), .busy(dev_busy));
  psram_monitor psram_monitor_i (.core_clk(core_clk), .rst(rst),
    .mem_clk_edge(link_if.mem_clk_edge), .ce_n(link_if.ce_n),
    .addr_valid_n(link_if.addr_valid_n), .we_n(link_if.we_n),
    .bus_config_reg(link_if.bus_config_reg), .dev_oe(link_if.dev_oe), .wait_n(link_if.wait_n));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Timeout, far above the thousand or so cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      test_done();
    end
  end
  // Link edges from address strobe to first edge with wait released
  always @(posedge core_clk) begin
    if (link_if.mem_clk_edge && !link_if.ce_n) begin
      if (!link_if.addr_valid_n) begin
        edge_cnt = 0;
        lat_seen = 0;
      end else begin
        edge_cnt++;
        if (link_if.wait_n && lat_seen == 0) lat_seen = edge_cnt;
      end
    end
  end
  // ********
  // Tasks
  // ********
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic burst(input logic [31:0] a, input logic [31:0] n, input logic [31:0] c);
    int k;
    k = 0;
    wr(REG_ADDR, a);
    wr(REG_LEN, n);
    wr(REG_CTRL, c);
    repeat (2) @(posedge core_clk);
    rd(REG_STATUS, rv);
    check(32'(dev_busy), 32'h0000_0001, "memory busy");
    while (rv[STAT_BUSY_BIT] !== 1'b0 && k < 300) begin
      rd(REG_STATUS, rv);
      k++;
    end
    check(32'(rv[STAT_BUSY_BIT]), 32'h0000_0000, "host idle");
  endtask
  task automatic drain(input logic [31:0] base, input int cnt);
    int k;
    for (int i = 0; i < cnt; i++) begin
      k = 0;
      rd(REG_STATUS, rv);
      while (rv[STAT_LEVEL_LO +: 5] == 5'h00 && k < 100) begin
        rd(REG_STATUS, rv);
        k++;
      end
      rd(REG_RDATA, rv);
      check(rv, base + 32'(i), "read word");
    end
  endtask
  // ********
  // Tests
  // ********
  initial begin
    rst = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(REG_CFG, rv);
    check(rv, 32'h0000_1807, "config reset");
    rd(3'h7, rv);
    check(rv, 32'h0000_0000, "unmapped read");
    rd(REG_RDATA, rv);
    check(rv, 32'h0000_0000, "empty pop");
    wr(REG_CTRL, 32'h0001_0001);
    rd(REG_STATUS, rv);
    check(rv, 32'h0000_0000, "go with upper bits");
    check(32'(dev_busy), 32'h0000_0000, "memory idle");
    $display("test registers done");
    for (int k = 0; k < 3; k++) begin
      wr(REG_CFG, {16'h0000, cfg_tab[k]});
      wr(REG_WDATA, 32'h0000_a000 + 32'(k * 16));
      burst(32'h0000_0010, 32'h0000_0004, 32'h0000_0003);
      check(32'(lat_seen), 32'(cfg_tab[k][13:11]) + 32'h0000_0001, "write latency");
      burst(32'h0000_0010, 32'h0000_0004, 32'h0000_0001);
      check(32'(lat_seen), 32'(cfg_tab[k][13:11]) + 32'h0000_0001, "read latency");
      rd(REG_STATUS, rv);
      check(rv, 32'h0000_0400, "defined burst level");
      drain(32'h0000_a000 + 32'(k * 16), 4);
    end
    $display("test latency done");
    wr(REG_CFG, 32'h0000_1807);
    wr(REG_WDATA, 32'h0000_b000);
    burst(32'h0000_001d, 32'h0000_0006, 32'h0000_0003);
    burst(32'h0000_001d, 32'h0000_0006, 32'h0000_0001);
    rd(REG_STATUS, rv);
    check(rv, 32'h0000_0600, "crossing level");
    drain(32'h0000_b000, 6);
    $display("test row crossing done");
    burst(32'h0000_001e, 32'h0000_0006, 32'h0000_0005);
    rd(REG_STATUS, rv);
    check(rv, 32'h0000_0202, "read row stop");
    drain(32'h0000_b001, 2);
    wr(REG_WDATA, 32'h0000_c000);
    burst(32'h0000_002e, 32'h0000_0006, 32'h0000_0007);
    rd(REG_STATUS, rv);
    check(rv, 32'h0000_0002, "write row stop");
    $display("test row stop done");
    wr(REG_WDATA, 32'h0000_d000);
    burst(32'h0000_0040, 32'h0000_0014, 32'h0000_0003);
    wr(REG_ADDR, 32'h0000_0040);
    wr(REG_LEN, 32'h0000_0014);
    wr(REG_CTRL, 32'h0000_0001);
    repeat (150) @(posedge core_clk);
    rd(REG_STATUS, rv);
    check(32'(rv[STAT_LEVEL_LO +: 5] >= 5'h0e), 32'h0000_0001, "fifo filled");
    check(32'(rv[STAT_BUSY_BIT]), 32'h0000_0001, "held while full");
    drain(32'h0000_d000, 20);
    rd(REG_RDATA, rv);
    check(rv, 32'h0000_0000, "drained empty");
    $display("test fifo done");
    test_done();
  end
endmodule // testbench
